// ---- hw/sfm_regs.svh ----
// Constants for the sensor frequency meter: timing counts and defaults.
// Assumes nothing of its surroundings; included by its bare name.
`ifndef SFM_REGS_SVH
`define SFM_REGS_SVH
`define SFM_CLK_HZ 125000000
`define SFM_GATE_MS 100
`define SFM_GATE_CYC ((`SFM_CLK_HZ / 1000) * `SFM_GATE_MS)
`define SFM_SCALE_DEF 10
`define SFM_NCYC_DEF 16'h0010
`define SFM_PRESCALE 4
`define SFM_TB_W 16
`define SFM_CNT_W 32
`endif

// ---- hw/sfm_pkg.sv ----
// Types shared by the sensor frequency meter.
// Assumes the constants header is compiled alongside.
package sfm_pkg;
	typedef enum logic [1:0] {
		SFM_IDLE = 2'b00,
		SFM_GATE = 2'b01,
		SFM_CYCL = 2'b10
	} sfm_state_t;
	typedef struct packed {
		logic [31:0] freq;
		logic [31:0] count;
	} sfm_time_res_t;
	typedef struct packed {
		logic [15:0] first_stamp;
		logic [15:0] elapsed;
	} sfm_cyc_res_t;
endpackage

// ---- hw/sfm_meter.sv ----
// Sensor frequency meter: fixed-time gate counting and fixed-cycle capture.
// Assumes a square wave on SENS_IN and a start pulse from the surrounding logic.
// Overview of operation
// - Sensor square wave enters on one digital input; schmitt pad suggested.
// - Fixed-time mode counts input pulses within a programmable gate window.
// - Frequency equals pulse count multiplied by the window-to-second factor.
// - A hardware counter accumulates cycles; an own timer forms the gate.
// - Fixed-cycle mode times a configured constant number of input cycles.
// - Elapsed time is latched from a 16-bit free-running timebase on edges.
// - Timebase advances once every four system clock cycles.
`timescale 1ns/1ps
`include "sfm_regs.svh"
module sfm_meter #(
	parameter int GATE_CYC = `SFM_GATE_CYC,
	parameter logic [31:0] SCALE = `SFM_SCALE_DEF,
	parameter logic [15:0] NCYC = `SFM_NCYC_DEF
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST_N,
	// Sensor input.
	input wire logic SENS_IN,
	// Control.
	input wire logic START,
	input wire logic MODE_CYCLE,
	// Results.
	output logic BUSY,
	output logic DONE,
	output sfm_pkg::sfm_time_res_t TIME_RES,
	output sfm_pkg::sfm_cyc_res_t CYC_RES,
	output logic [15:0] TIMEBASE
);
	logic rst_s1_q, rst_s2_q;
	logic in_s1_q, in_s2_q, in_d_q;
	logic rise;
	logic [1:0] pre_q;
	logic [15:0] tb_q;
	sfm_pkg::sfm_state_t st_q;
	logic [31:0] gate_q;
	logic [31:0] cnt_q;
	logic [15:0] ncnt_q;
	logic [15:0] stamp_q;
	logic armed_q;
	logic done_q;
	sfm_pkg::sfm_time_res_t tres_q;
	sfm_pkg::sfm_cyc_res_t cres_q;
	wire rst_n = rst_s2_q;

	// Count with a same-cycle rise folded in, so the last gate cycle never loses an edge.
	function automatic logic [31:0] add_rise(input logic [31:0] cnt, input logic edge_seen);
		add_rise = cnt + {31'h0, edge_seen};
	endfunction

	// Reset release through two flip-flops so release is clean to CLK.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// The sensor pin is asynchronous, so it is synchronised before any use.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			in_s1_q <= 1'b0;
			in_s2_q <= 1'b0;
			in_d_q <= 1'b0;
		end else begin
			in_s1_q <= SENS_IN;
			in_s2_q <= in_s1_q;
			in_d_q <= in_s2_q;
		end
	end
	assign rise = in_s2_q & ~in_d_q;

	// Quarter-rate free-running timebase; wraps, so elapsed uses modular difference.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 2'h0;
			tb_q <= 16'h0000;
		end else begin
			pre_q <= pre_q + 2'h1;
			if (pre_q == 2'h3) begin
				tb_q <= tb_q + 16'h0001;
			end
		end
	end

	// Measurement sequencer; START while busy is ignored.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= sfm_pkg::SFM_IDLE;
			gate_q <= 32'h0;
			cnt_q <= 32'h0;
			ncnt_q <= 16'h0000;
			stamp_q <= 16'h0000;
			armed_q <= 1'b0;
			done_q <= 1'b0;
			tres_q <= '0;
			cres_q <= '0;
		end else begin
			done_q <= 1'b0;
			unique case (st_q)
				sfm_pkg::SFM_IDLE: begin
					if (START) begin
						gate_q <= 32'(GATE_CYC - 1);
						cnt_q <= 32'h0;
						ncnt_q <= 16'h0000;
						armed_q <= 1'b0;
						st_q <= MODE_CYCLE ? sfm_pkg::SFM_CYCL : sfm_pkg::SFM_GATE;
					end
				end
				sfm_pkg::SFM_GATE: begin
					if (rise) begin
						cnt_q <= cnt_q + 32'h1;
					end
					if (gate_q == 32'h0) begin
						// A rise in the final gate cycle still belongs to the window.
						tres_q.count <= add_rise(cnt_q, rise);
						tres_q.freq <= 32'(add_rise(cnt_q, rise) * SCALE);
						done_q <= 1'b1;
						st_q <= sfm_pkg::SFM_IDLE;
					end else begin
						gate_q <= gate_q - 32'h1;
					end
				end
				sfm_pkg::SFM_CYCL: begin
					if (rise) begin
						if (!armed_q) begin
							stamp_q <= tb_q;
							armed_q <= 1'b1;
						end else if (ncnt_q == NCYC - 16'h0001) begin
							cres_q.first_stamp <= stamp_q;
							cres_q.elapsed <= tb_q - stamp_q;
							done_q <= 1'b1;
							st_q <= sfm_pkg::SFM_IDLE;
						end else begin
							ncnt_q <= ncnt_q + 16'h0001;
						end
					end
				end
				default: st_q <= sfm_pkg::SFM_IDLE;
			endcase
		end
	end

	assign BUSY = (st_q != sfm_pkg::SFM_IDLE);
	assign DONE = done_q;
	assign TIME_RES = tres_q;
	assign CYC_RES = cres_q;
	assign TIMEBASE = tb_q;

	// Checks.
	property p_tb_rate;
		@(posedge CLK) disable iff (!rst_n)
		(pre_q == 2'h3) |=> (tb_q == $past(tb_q) + 16'h0001);
	endproperty
	a_tb_rate: assert property (p_tb_rate) else $error("timebase step wrong");
	property p_tb_hold;
		@(posedge CLK) disable iff (!rst_n)
		(pre_q != 2'h3) |=> $stable(tb_q);
	endproperty
	a_tb_hold: assert property (p_tb_hold) else $error("timebase moved early");
	property p_rise;
		@(posedge CLK) disable iff (!rst_n)
		rise |-> ($past(SENS_IN, 2) && !$past(SENS_IN, 3));
	endproperty
	a_rise: assert property (p_rise) else $error("bad edge detect");
	property p_freq;
		@(posedge CLK) disable iff (!rst_n)
		(done_q && $past(st_q) == sfm_pkg::SFM_GATE) |->
			(tres_q.freq == 32'(tres_q.count * SCALE));
	endproperty
	a_freq: assert property (p_freq) else $error("frequency scale wrong");
	property p_cnt;
		@(posedge CLK) disable iff (!rst_n)
		(st_q == sfm_pkg::SFM_GATE && gate_q != 32'h0 && rise) |=> (cnt_q == $past(cnt_q) + 32'h1);
	endproperty
	a_cnt: assert property (p_cnt) else $error("pulse not counted");
	property p_gate;
		@(posedge CLK) disable iff (!rst_n)
		(st_q == sfm_pkg::SFM_GATE && gate_q == 32'h0) |=> (done_q && !BUSY);
	endproperty
	a_gate: assert property (p_gate) else $error("gate end missed");
	property p_cyc_done;
		@(posedge CLK) disable iff (!rst_n)
		(st_q == sfm_pkg::SFM_CYCL && rise && armed_q && ncnt_q == NCYC - 16'h0001)
			|=> (done_q && cres_q.elapsed == $past(tb_q) - $past(stamp_q));
	endproperty
	a_cyc_done: assert property (p_cyc_done) else $error("elapsed wrong");
	property p_done_pulse;
		@(posedge CLK) disable iff (!rst_n)
		done_q |=> !done_q;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");
	property p_ncnt;
		@(posedge CLK) disable iff (!rst_n)
		(st_q == sfm_pkg::SFM_CYCL) |-> (ncnt_q < NCYC);
	endproperty
	a_ncnt: assert property (p_ncnt) else $error("cycle count overrun");
	property p_start;
		@(posedge CLK) disable iff (!rst_n)
		(st_q == sfm_pkg::SFM_IDLE && START) |=>
			(BUSY && cnt_q == 32'h0 && ncnt_q == 16'h0000 && !armed_q);
	endproperty
	a_start: assert property (p_start) else $error("start not taken cleanly");
	property p_stamp;
		@(posedge CLK) disable iff (!rst_n)
		(st_q == sfm_pkg::SFM_CYCL && rise && !armed_q) |=>
			(armed_q && stamp_q == $past(tb_q));
	endproperty
	a_stamp: assert property (p_stamp) else $error("first edge not stamped");
	property p_tres_hold;
		@(posedge CLK) disable iff (!rst_n)
		!(st_q == sfm_pkg::SFM_GATE && gate_q == 32'h0) |=> $stable(tres_q);
	endproperty
	a_tres_hold: assert property (p_tres_hold) else $error("gate result moved");
	property p_cres_hold;
		@(posedge CLK) disable iff (!rst_n)
		!(st_q == sfm_pkg::SFM_CYCL && rise && armed_q && ncnt_q == NCYC - 16'h0001)
			|=> $stable(cres_q);
	endproperty
	a_cres_hold: assert property (p_cres_hold) else $error("cycle result moved");
	c_gate: cover property (@(posedge CLK) disable iff (!rst_n)
		done_q && $past(st_q) == sfm_pkg::SFM_GATE);
	c_cyc: cover property (@(posedge CLK) disable iff (!rst_n)
		done_q && $past(st_q) == sfm_pkg::SFM_CYCL);
	c_wrap: cover property (@(posedge CLK) disable iff (!rst_n)
		tb_q == 16'hffff && pre_q == 2'h3);
	c_refused: cover property (@(posedge CLK) disable iff (!rst_n)
		BUSY && START);
	c_last_rise: cover property (@(posedge CLK) disable iff (!rst_n)
		st_q == sfm_pkg::SFM_GATE && gate_q == 32'h0 && rise);
endmodule

// ---- bench/sfm_osc_model.sv ----
// Behavioural model of the sensor oscillator that feeds the meter.
// Assumes an 8 ns system clock; half is given in system clock cycles.
`timescale 1ns/1ps
module sfm_osc_model (
	// Burst control.
	input wire logic en,
	input wire logic [7:0] half,
	// Square wave toward the single sensor input.
	output logic wave
);
	// The wave stands low outside bursts, so a stale level never fakes an edge.
	always begin
		wave = 1'b0;
		wait (en);
		while (en) begin
			#(half * 8);
			wave = ~wave;
		end
	end
endmodule

// ---- bench/sensor_frequency_meter_bench.sv ----
// Self-checking bench for the sensor frequency meter.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ps
module sensor_frequency_meter_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	logic mode_cycle = 1'b0;
	logic osc_en = 1'b0;
	logic [7:0] half = 8'h14;
	logic sens;
	logic busy;
	logic done;
	logic [15:0] tb_now;
	sfm_pkg::sfm_time_res_t time_res;
	sfm_pkg::sfm_cyc_res_t cyc_res;
	int miscompares = 0;
	int checked = 0;
	// Short gate keeps the run small; expectations follow these values.
	sfm_meter #(.GATE_CYC(200), .SCALE(32'h0000000a), .NCYC(16'h0004)) u_sfm_meter (
		.CLK(clk), .RST_N(rst_n), .SENS_IN(sens), .START(start), .MODE_CYCLE(mode_cycle),
		.BUSY(busy), .DONE(done), .TIME_RES(time_res), .CYC_RES(cyc_res), .TIMEBASE(tb_now));
	sfm_osc_model u_sfm_osc_model (.en(osc_en), .half(half), .wave(sens));
	// The 125 MHz clock.
	always #4 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Launches a run and the oscillator burst on the same falling edge.
	task automatic pulse_start(input logic mode);
		@(negedge clk);
		start = 1'b1;
		mode_cycle = mode;
		osc_en = 1'b1;
		@(negedge clk);
		start = 1'b0;
	endtask
	task automatic timebase_run();
		logic [15:0] t0;
		t0 = tb_now;
		repeat (8) @(negedge clk);
		check({16'h0000, tb_now}, {16'h0000, t0 + 16'h0002});
	endtask
	// Five rises and five falls fall in the gate; a second START mid-gate must be ignored.
	task automatic fixed_time_run();
		int n;
		n = 0;
		half = 8'h14;
		pulse_start(1'b0);
		while (done !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
			start = (n == 50);
			mode_cycle = (n == 50);
		end
		check(n, 200);
		check(time_res.count, 32'h00000005);
		check(time_res.freq, 32'h00000032);
		check(cyc_res, 32'h00000000);
		check({31'h0, busy}, 32'h00000000);
		osc_en = 1'b0;
		repeat (40) @(negedge clk);
	endtask
	// Period of 20 cycles is 5 timebase ticks, so four periods span 20 ticks.
	task automatic fixed_cycle_run();
		int n;
		n = 0;
		half = 8'h0a;
		pulse_start(1'b1);
		while (done !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		// Fifth rise comes 90 cycles into the burst; sync stages and result register follow.
		check(n, 92);
		check({16'h0000, cyc_res.elapsed}, 32'h00000014);
		// The timebase steps every fourth edge from reset release, so the first stamp is 66.
		check({16'h0000, cyc_res.first_stamp}, 32'h00000042);
		check(time_res.count, 32'h00000005);
		osc_en = 1'b0;
	endtask
	// Main sequence: reset for 16 cycles, then each scenario in turn.
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		timebase_run();
		fixed_time_run();
		fixed_cycle_run();
		print_verdict();
	end
	// Watchdog well beyond the few hundred cycles the scenarios need.
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end
endmodule
